// file: hdl/fbme_exec.sv
// Functional notes
// - Signed GE branches when N xor V is 0.
// - Signed LT branches when N xor V is 1.
// - Half-carry-set branch taken only when H is 1.
// - Half-carry-clear branch taken only when H is 0.
// - Copy-bit-set branch taken only when T is 1.
// - Copy-bit-clear branch taken only when T is 0.
// - Overflow-set branch taken only when V is 1.
// - Overflow-clear branch taken only when V is 0.
// - Irq-enabled branch taken only when I is 1.
// - Irq-disabled branch taken only when I is 0.
// - Taken: PC+k+1, two cycles; else one; flags kept.
// - Single register copy, one cycle, flags kept.
// - Register pair copy, one cycle, flags kept.
// - Direct load from constant address, two cycles.
// - Load at pointer, then pointer plus one, one cycle.
// - Pointer minus one, then load, two cycles.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`include "fbme_defines.svh"
module fbme_exec (
  // Clock and reset
  input  logic        clk,
  input  logic        sys_rst,
  // APB slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Data space read port
  output logic [15:0] ds_addr,
  output logic        ds_re,
  input  logic [7:0]  ds_rdata
);

  fbme_pkg::fbme_state_type state_q;

  logic [15:0] instr_q;
  logic [15:0] word2_q;
  logic [15:0] pc_q;
  logic [7:0]  sreg_q;
  logic [4:0]  regidx_q;
  logic        taken_q;
  logic        illegal_q;
  logic [1:0]  cycles_q;
  logic [15:0] ds_addr_q;
  logic        ds_re_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  logic [3:0]  op;
  logic [4:0]  dst;
  logic [4:0]  src;
  logic        is_branch;
  logic        is_legal;
  logic        take;
  logic        two_cycle;
  logic [15:0] k_ext;
  logic [15:0] rd_a_data;
  logic [15:0] rd_b_data;
  logic [3:0]  rd_a_pair;
  logic [7:0]  src_byte;
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic        busy;

  logic [3:0]  w1_pair;
  logic [1:0]  w1_mask;
  logic [15:0] w1_data;
  logic [3:0]  w2_pair;
  logic [1:0]  w2_mask;
  logic [15:0] w2_data;

  logic        apb_first;
  logic        apb_done;
  logic        apb_wr;
  logic [5:0]  apb_word;
  logic        apb_mapped;
  logic [31:0] rd_mux;
  logic        launch;

  assign op        = instr_q[`FBME_F_OP];
  assign dst       = instr_q[`FBME_F_DST];
  assign src       = instr_q[`FBME_F_SRC];
  assign is_branch = (op <= `FBME_OP_BR_ID);
  assign is_legal  = (op <= `FBME_OP_LOAD_DEC);
  assign busy      = (state_q != fbme_pkg::FBME_IDLE);

  // The displacement is sign extended before the add, so backward targets wrap correctly.
  assign k_ext = {{`FBME_K_EXT_W{instr_q[`FBME_F_K_SIGN]}}, instr_q[`FBME_F_K]};

  assign two_cycle = (is_branch && take) || op == `FBME_OP_LOAD_DIR || op == `FBME_OP_LOAD_DEC;

  // Pointer ops read the pointer pair, everything else the source pair.
  assign rd_a_pair = (op == `FBME_OP_LOAD_INC || op == `FBME_OP_LOAD_DEC) ?
                     `FBME_PTR_PAIR : src[4:1];
  assign src_byte  = src[0] ? rd_a_data[15:8] : rd_a_data[7:0];
  assign ptr_inc   = rd_a_data + `FBME_STEP_ONE;
  assign ptr_dec   = rd_a_data - `FBME_STEP_ONE;

  fbme_branch_cond u_cond (
    .op   (op),
    .sreg (sreg_q),
    .take (take)
  );

  fbme_regfile u_regs (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .rd_a_pair   (rd_a_pair),
    .rd_a_data_q (rd_a_data),
    .rd_b_pair   (regidx_q[4:1]),
    .rd_b_data_q (rd_b_data),
    .w1_pair     (w1_pair),
    .w1_mask     (w1_mask),
    .w1_data     (w1_data),
    .w2_pair     (w2_pair),
    .w2_mask     (w2_mask),
    .w2_data     (w2_data)
  );

  // Destination write port.
  always_comb
  begin
    w1_pair = dst[4:1];
    w1_mask = 2'h0;
    w1_data = {ds_rdata, ds_rdata};
    if (state_q == fbme_pkg::FBME_EXEC1)
    begin
      unique case (op)
        `FBME_OP_CP_ONE:
        begin
          w1_mask = dst[0] ? 2'h2 : 2'h1;
          w1_data = {src_byte, src_byte};
        end
        `FBME_OP_CP_PAIR:
        begin
          w1_mask = 2'h3;
          w1_data = rd_a_data;
        end
        `FBME_OP_LOAD_INC:
          w1_mask = dst[0] ? 2'h2 : 2'h1;
        default:
          w1_mask = 2'h0;
      endcase
    end
    else if (state_q == fbme_pkg::FBME_EXEC2 &&
             (op == `FBME_OP_LOAD_DIR || op == `FBME_OP_LOAD_DEC))
      w1_mask = dst[0] ? 2'h2 : 2'h1;
  end

  // Pointer write port, shared with software access while idle.
  always_comb
  begin
    w2_pair = `FBME_PTR_PAIR;
    w2_mask = 2'h0;
    w2_data = ptr_inc;
    if (state_q == fbme_pkg::FBME_EXEC1 && op == `FBME_OP_LOAD_INC)
      w2_mask = 2'h3;
    else if (state_q == fbme_pkg::FBME_EXEC1 && op == `FBME_OP_LOAD_DEC)
    begin
      w2_mask = 2'h3;
      w2_data = ptr_dec;
    end
    else if (apb_wr && apb_word == `FBME_OFF_REGDATA)
    begin
      w2_pair = regidx_q[4:1];
      w2_mask = regidx_q[0] ? 2'h2 : 2'h1;
      w2_data = {pwdata[7:0], pwdata[7:0]};
    end
  end

  // Sequencer: READ and PREP fetch operands, EXEC1/EXEC2 are the counted cycles.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= fbme_pkg::FBME_IDLE;
    else
    begin
      unique case (state_q)
        fbme_pkg::FBME_IDLE:  if (launch) state_q <= fbme_pkg::FBME_READ;
        fbme_pkg::FBME_READ:  state_q <= fbme_pkg::FBME_PREP;
        fbme_pkg::FBME_PREP:  state_q <= fbme_pkg::FBME_EXEC1;
        fbme_pkg::FBME_EXEC1: state_q <= two_cycle ? fbme_pkg::FBME_EXEC2 : fbme_pkg::FBME_IDLE;
        fbme_pkg::FBME_EXEC2: state_q <= fbme_pkg::FBME_IDLE;
      endcase
    end
  end

  // Program counter; the status flags are never written by execution.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pc_q <= `FBME_PC_RST;
    else if (state_q == fbme_pkg::FBME_EXEC1)
    begin
      if (is_branch && take)
        pc_q <= pc_q + k_ext + `FBME_STEP_ONE;
      else if (op == `FBME_OP_LOAD_DIR)
        pc_q <= pc_q + `FBME_STEP_TWO;
      else
        pc_q <= pc_q + `FBME_STEP_ONE;
    end
    else if (apb_wr && apb_word == `FBME_OFF_PC)
      pc_q <= pwdata[15:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sreg_q <= `FBME_SREG_RST;
    else if (apb_wr && apb_word == `FBME_OFF_SREG)
      sreg_q <= pwdata[7:0];
  end

  // Data-space address and read strobe.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ds_addr_q <= 16'h0000;
      ds_re_q   <= 1'b0;
    end
    else if (state_q == fbme_pkg::FBME_PREP && op == `FBME_OP_LOAD_DIR)
    begin
      ds_addr_q <= word2_q;
      ds_re_q   <= 1'b1;
    end
    else if (state_q == fbme_pkg::FBME_PREP && op == `FBME_OP_LOAD_INC)
    begin
      ds_addr_q <= rd_a_data;
      ds_re_q   <= 1'b1;
    end
    else if (state_q == fbme_pkg::FBME_EXEC1 && op == `FBME_OP_LOAD_DEC)
    begin
      ds_addr_q <= ptr_dec;
      ds_re_q   <= 1'b1;
    end
    else if (state_q == fbme_pkg::FBME_EXEC2 ||
             (state_q == fbme_pkg::FBME_EXEC1 && op != `FBME_OP_LOAD_DIR))
      ds_re_q <= 1'b0;
  end

  // Outcome of the last instruction.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      taken_q   <= 1'b0;
      illegal_q <= 1'b0;
      cycles_q  <= 2'h0;
    end
    else if (state_q == fbme_pkg::FBME_EXEC1)
    begin
      taken_q   <= is_branch && take;
      illegal_q <= ~is_legal;
      cycles_q  <= `FBME_CYC_ONE;
    end
    else if (state_q == fbme_pkg::FBME_EXEC2)
      cycles_q <= `FBME_CYC_TWO;
  end

  // Instruction words and register index.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      instr_q  <= `FBME_INSTR_RST;
      word2_q  <= `FBME_INSTR_RST;
      regidx_q <= 5'h00;
    end
    else if (launch)
    begin
      instr_q <= pwdata[15:0];
      word2_q <= pwdata[31:16];
    end
    else if (apb_wr && apb_word == `FBME_OFF_REGIDX)
      regidx_q <= pwdata[4:0];
  end

  // APB slave: every access gets exactly one wait state.
  assign apb_first  = psel && penable && !pready_q;
  assign apb_done   = psel && penable && pready_q;
  assign apb_word   = paddr[7:2];
  assign apb_wr     = apb_done && pwrite && !pslverr_q;
  assign launch     = apb_wr && apb_word == `FBME_OFF_INSTR;
  assign apb_mapped = (apb_word <= `FBME_OFF_REGDATA);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (apb_word)
      `FBME_OFF_INSTR:   rd_mux = {word2_q, instr_q};
      `FBME_OFF_PC:      rd_mux = {16'h0000, pc_q};
      `FBME_OFF_SREG:    rd_mux = {24'h00_0000, sreg_q};
      `FBME_OFF_STATUS:
      begin
        rd_mux[`FBME_ST_BUSY]    = busy;
        rd_mux[`FBME_ST_TAKEN]   = taken_q;
        rd_mux[`FBME_ST_ILLEGAL] = illegal_q;
        rd_mux[`FBME_ST_CYC]     = cycles_q;
      end
      `FBME_OFF_REGIDX:  rd_mux = {27'h000_0000, regidx_q};
      `FBME_OFF_REGDATA: rd_mux = {24'h00_0000,
                                   regidx_q[0] ? rd_b_data[15:8] : rd_b_data[7:0]};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Writes while busy are refused so software cannot race the sequencer.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= apb_first;
      pslverr_q <= apb_first && (!apb_mapped ||
                   (pwrite && (busy || apb_word == `FBME_OFF_STATUS)));
      prdata_q  <= (apb_first && !pwrite && apb_mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign ds_addr = ds_addr_q;
  assign ds_re   = ds_re_q;

endmodule

// file: hdl/fbme_defines.svh
`ifndef FBME_DEFINES_SVH
`define FBME_DEFINES_SVH

// APB register word indices; the byte address is four times the index.
`define FBME_OFF_INSTR   6'h00
`define FBME_OFF_PC      6'h01
`define FBME_OFF_SREG    6'h02
`define FBME_OFF_STATUS  6'h03
`define FBME_OFF_REGIDX  6'h04
`define FBME_OFF_REGDATA 6'h05

// Reset values.
`define FBME_PC_RST      16'h0000
`define FBME_SREG_RST    8'h00
`define FBME_INSTR_RST   16'h0000

// Status register flag positions.
`define FBME_FLAG_C      0
`define FBME_FLAG_Z      1
`define FBME_FLAG_N      2
`define FBME_FLAG_V      3
`define FBME_FLAG_S      4
`define FBME_FLAG_H      5
`define FBME_FLAG_T      6
`define FBME_FLAG_I      7

// STATUS register field positions.
`define FBME_ST_BUSY     0
`define FBME_ST_TAKEN    1
`define FBME_ST_ILLEGAL  2
`define FBME_ST_CYC      5:4

// Instruction word fields.
`define FBME_F_OP        15:12
`define FBME_F_DST       11:7
`define FBME_F_SRC       6:2
`define FBME_F_K         6:0
`define FBME_F_K_SIGN    6
`define FBME_K_EXT_W     9

// Operation codes.
`define FBME_OP_BR_GE    4'h0
`define FBME_OP_BR_LT    4'h1
`define FBME_OP_BR_HS    4'h2
`define FBME_OP_BR_HC    4'h3
`define FBME_OP_BR_TS    4'h4
`define FBME_OP_BR_TC    4'h5
`define FBME_OP_BR_VS    4'h6
`define FBME_OP_BR_VC    4'h7
`define FBME_OP_BR_IE    4'h8
`define FBME_OP_BR_ID    4'h9
`define FBME_OP_CP_ONE   4'hA
`define FBME_OP_CP_PAIR  4'hB
`define FBME_OP_LOAD_DIR 4'hC
`define FBME_OP_LOAD_INC 4'hD
`define FBME_OP_LOAD_DEC 4'hE

// Pointer pair index (registers 27:26), steps and cycle counts.
`define FBME_PTR_PAIR    4'hD
`define FBME_STEP_ONE    16'h0001
`define FBME_STEP_TWO    16'h0002
`define FBME_CYC_ONE     2'h1
`define FBME_CYC_TWO     2'h2

`endif

// file: hdl/fbme_pkg.sv
package fbme_pkg;

  typedef enum logic [4:0] {
    FBME_IDLE  = 5'h01,
    FBME_READ  = 5'h02,
    FBME_PREP  = 5'h04,
    FBME_EXEC1 = 5'h08,
    FBME_EXEC2 = 5'h10
  } fbme_state_type;

endpackage

// file: hdl/fbme_regfile.sv
`timescale 1ns/1ns
module fbme_regfile (
  // Clock and reset
  input  logic        clk,
  input  logic        sys_rst,
  // Read ports, pair addressed
  input  logic [3:0]  rd_a_pair,
  output logic [15:0] rd_a_data_q,
  input  logic [3:0]  rd_b_pair,
  output logic [15:0] rd_b_data_q,
  // Write port one, has priority
  input  logic [3:0]  w1_pair,
  input  logic [1:0]  w1_mask,
  input  logic [15:0] w1_data,
  // Write port two
  input  logic [3:0]  w2_pair,
  input  logic [1:0]  w2_mask,
  input  logic [15:0] w2_data
);

  logic [7:0] mem_q [0:31];

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_ent
      localparam logic [3:0] PAIR = 4'(i / 2);
      localparam int         LANE = i % 2;
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          mem_q[i] <= 8'h00;
        else if (w1_mask[LANE] && w1_pair == PAIR)
          mem_q[i] <= w1_data[LANE*8 +: 8];
        else if (w2_mask[LANE] && w2_pair == PAIR)
          mem_q[i] <= w2_data[LANE*8 +: 8];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_a_data_q <= 16'h0000;
      rd_b_data_q <= 16'h0000;
    end
    else
    begin
      rd_a_data_q <= {mem_q[{rd_a_pair, 1'b1}], mem_q[{rd_a_pair, 1'b0}]};
      rd_b_data_q <= {mem_q[{rd_b_pair, 1'b1}], mem_q[{rd_b_pair, 1'b0}]};
    end
  end

endmodule

// file: hdl/fbme_branch_cond.sv
`timescale 1ns/1ns
`include "fbme_defines.svh"
module fbme_branch_cond (
  // Decoded operation and flags
  input  logic [3:0] op,
  input  logic [7:0] sreg,
  // Branch decision
  output logic       take
);

  logic sign_diff;

  assign sign_diff = sreg[`FBME_FLAG_N] ^ sreg[`FBME_FLAG_V];

  always_comb
  begin
    case (op)
      `FBME_OP_BR_GE: take = (sign_diff == 1'b0);
      `FBME_OP_BR_LT: take = (sign_diff == 1'b1);
      `FBME_OP_BR_HS: take = sreg[`FBME_FLAG_H];
      `FBME_OP_BR_HC: take = ~sreg[`FBME_FLAG_H];
      `FBME_OP_BR_TS: take = sreg[`FBME_FLAG_T];
      `FBME_OP_BR_TC: take = ~sreg[`FBME_FLAG_T];
      `FBME_OP_BR_VS: take = sreg[`FBME_FLAG_V];
      `FBME_OP_BR_VC: take = ~sreg[`FBME_FLAG_V];
      `FBME_OP_BR_IE: take = sreg[`FBME_FLAG_I];
      `FBME_OP_BR_ID: take = ~sreg[`FBME_FLAG_I];
      default:        take = 1'b0;
    endcase
  end

endmodule

// file: verification/fbme_exec_properties.sv
`timescale 1ns/1ns
module fbme_exec_checker (
  // Clock and reset
  input logic        clk,
  input logic        sys_rst,
  // Register bus
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Data space read port
  input logic [15:0] ds_addr,
  input logic        ds_re
);
  logic launch;
  logic access;
  assign access = psel && penable && !pready;
  assign launch = pready && psel && pwrite && paddr[7:2] == 6'h00 && !pslverr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_ready_wait;
    access |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_rdata_quiet;
    !pready |-> prdata == 32'h00000000;
  endproperty
  property p_unmapped;
    access && paddr[7:2] > 6'h05 |=> pslverr && prdata == 32'h00000000;
  endproperty
  property p_status_ro;
    access && pwrite && paddr[7:2] == 6'h03 |=> pslverr;
  endproperty
  property p_busy_refuse;
    launch |=> !launch [*4];
  endproperty
  property p_strobe_cause;
    $rose(ds_re) |-> $past(launch, 3) || $past(launch, 4);
  endproperty
  property p_strobe_max;
    ds_re ##1 ds_re |=> !ds_re;
  endproperty
  property p_addr_hold;
    ds_re && $past(ds_re) |-> $stable(ds_addr);
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("pready missing after access");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("prdata nonzero outside answer");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_status_ro: assert property (p_status_ro)
    else $error("status write not refused");
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("launch accepted while busy");
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("read strobe without launch");
  a_strobe_max: assert property (p_strobe_max)
    else $error("read strobe too long");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved under strobe");
  c_launch: cover property (launch);
  c_strobe: cover property ($rose(ds_re));
  c_refused: cover property (pready && pslverr);
endmodule

bind fbme_exec fbme_exec_checker i_fbme_exec_checker (.clk, .sys_rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .ds_addr, .ds_re);

// file: verification/fbme_data_mem.sv
`timescale 1ns/1ns
module fbme_data_mem (
  // Read port
  input  logic [15:0] ds_addr,
  input  logic        ds_re,
  output logic [7:0]  ds_rdata
);
  logic [7:0] last_q;
  always @*
    if (ds_re)
      last_q = ds_addr[7:0] ^ ds_addr[15:8] ^ 8'h3C;
  // Off the strobe the inverse shows, so a sample at the wrong edge fails.
  assign ds_rdata = ds_re ? last_q : ~last_q;
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns
`include "fbme_defines.svh"
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] ds_addr;
  logic        ds_re;
  logic [7:0]  ds_rdata;
  int          n_errors = 0;
  int          n_checks = 0;
  logic [31:0] q;
  logic [31:0] st;
  logic        e;
  logic [7:0]  s;
  logic [6:0]  k;
  logic        tk;
  logic [7:0]  pats [4] = '{8'h00, 8'hE4, 8'h08, 8'h0C};
  always #5 clk = ~clk;
  fbme_exec i_fbme_exec (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ds_addr, .ds_re, .ds_rdata);
  fbme_data_mem i_fbme_data_mem (.ds_addr, .ds_re, .ds_rdata);
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input logic wr, input logic [5:0] w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {w, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      end_sim;
    end
  endtask
  task idle;
    int n;
    n = 0;
    do
    begin
      apb(0, `FBME_OFF_STATUS, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 20);
    st = q;
    if (q[0] !== 1'b0)
    begin
      n_errors++;
      end_sim;
    end
  endtask
  task run(input logic [31:0] ins, input logic [15:0] pc0, input logic [15:0] pc1,
           input logic [1:0] cyc);
    apb(1, `FBME_OFF_PC, {16'h0, pc0});
    apb(1, `FBME_OFF_INSTR, ins);
    idle;
    chk("cycles", {30'h0, cyc}, {30'h0, st[5:4]});
    apb(0, `FBME_OFF_PC, 32'h0);
    chk("pc", {16'h0, pc1}, q);
    apb(0, `FBME_OFF_SREG, 32'h0);
    chk("sreg", {24'h0, s}, q);
  endtask
  task setreg(input logic [4:0] i, input logic [7:0] v);
    apb(1, `FBME_OFF_REGIDX, {27'h0, i});
    apb(1, `FBME_OFF_REGDATA, {24'h0, v});
  endtask
  task getreg(input logic [4:0] i, input logic [7:0] x);
    apb(1, `FBME_OFF_REGIDX, {27'h0, i});
    apb(0, `FBME_OFF_REGDATA, 32'h0);
    chk("reg", {24'h0, x}, q);
  endtask
  function logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  function logic taken(input logic [3:0] o, input logic [7:0] f);
    logic nv;
    nv = f[`FBME_FLAG_N] ^ f[`FBME_FLAG_V];
    case (o)
      `FBME_OP_BR_GE: return !nv;
      `FBME_OP_BR_LT: return nv;
      `FBME_OP_BR_HS: return f[`FBME_FLAG_H];
      `FBME_OP_BR_HC: return !f[`FBME_FLAG_H];
      `FBME_OP_BR_TS: return f[`FBME_FLAG_T];
      `FBME_OP_BR_TC: return !f[`FBME_FLAG_T];
      `FBME_OP_BR_VS: return f[`FBME_FLAG_V];
      `FBME_OP_BR_VC: return !f[`FBME_FLAG_V];
      `FBME_OP_BR_IE: return f[`FBME_FLAG_I];
      default: return !f[`FBME_FLAG_I];
    endcase
  endfunction
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    s = 8'h00;
    idle;
    chk("status", 32'h0, st);
    apb(0, `FBME_OFF_PC, 32'h0);
    chk("pc reset", 32'h0, q);
    apb(0, `FBME_OFF_SREG, 32'h0);
    chk("sreg reset", 32'h0, q);
    getreg(5'd26, 8'h00);
    apb(0, 6'h06, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1, `FBME_OFF_STATUS, 32'h3);
    chk("status ro", 32'h1, {31'h0, e});
    $display("reset and map test done");
    for (int p = 0; p < 4; p++)
      for (int o = 0; o <= 9; o++)
      begin
        s = pats[p];
        k = p[0] ? 7'h7C : 7'h05;
        tk = taken(o[3:0], s);
        apb(1, `FBME_OFF_SREG, {24'h0, s});
        run({16'h0, o[3:0], 5'h00, k}, 16'h0100, tk ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101,
            tk ? 2'h2 : 2'h1);
        chk("taken", {31'h0, tk}, {31'h0, st[1]});
      end
    $display("branch test done");
    s = 8'hA5;
    apb(1, `FBME_OFF_SREG, {24'h0, s});
    setreg(5'd3, 8'h5A);
    setreg(5'd4, 8'h11);
    setreg(5'd5, 8'h22);
    run({16'h0, `FBME_OP_CP_ONE, 5'd7, 5'd3, 2'h0}, 16'h0200, 16'h0201, 2'h1);
    chk("taken copy", 32'h0, {31'h0, st[1]});
    getreg(5'd7, 8'h5A);
    run({16'h0, `FBME_OP_CP_PAIR, 5'd10, 5'd4, 2'h0}, 16'h0300, 16'h0301, 2'h1);
    getreg(5'd10, 8'h11);
    getreg(5'd11, 8'h22);
    run({16'h1234, `FBME_OP_LOAD_DIR, 5'd1, 7'h00}, 16'h0400, 16'h0402, 2'h2);
    getreg(5'd1, mem(16'h1234));
    setreg(5'd26, 8'hFF);
    run({16'h0, `FBME_OP_LOAD_INC, 5'd2, 7'h00}, 16'h0500, 16'h0501, 2'h1);
    getreg(5'd2, mem(16'h00FF));
    getreg(5'd27, 8'h01);
    run({16'h0, `FBME_OP_LOAD_DEC, 5'd9, 7'h00}, 16'h0600, 16'h0601, 2'h2);
    getreg(5'd9, mem(16'h00FF));
    getreg(5'd26, 8'hFF);
    getreg(5'd27, 8'h00);
    run({16'h0, 4'hF, 12'h000}, 16'h0700, 16'h0701, 2'h1);
    chk("illegal", 32'h1, {31'h0, st[2]});
    $display("move and load test done");
    apb(1, `FBME_OFF_INSTR, {16'h0, `FBME_OP_CP_ONE, 5'd8, 5'd3, 2'h0});
    apb(1, `FBME_OFF_INSTR, {16'h0, `FBME_OP_CP_ONE, 5'd12, 5'd3, 2'h0});
    chk("busy err", 32'h1, {31'h0, e});
    idle;
    chk("illegal clear", 32'h0, {31'h0, st[2]});
    getreg(5'd8, 8'h5A);
    getreg(5'd12, 8'h00);
    $display("busy test done");
    end_sim;
  end
endmodule
